// ---- mpeg_pkg.sv ----
// Purpose: Constants and types of the multimode pwm edge generator
// Assumes: 16-bit counter and edge values, 32-bit register port
// Notes:   Register offsets are byte addresses, one word each
package mpeg_pkg;

    // ==========================================================
    // Widths
    localparam int DW = 16;
    localparam int AW = 8;
    localparam int BW = 32;

    // ==========================================================
    // Register offsets
    localparam logic [AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AW-1:0] OFS_STAT = 8'h40;
    localparam logic [AW-1:0] OFS_LAST_CFG = 8'h3C;
    localparam int ADR_LSB = 2;

    // Config array indices (offset / 4)
    localparam int IDX_PRD = 1;
    localparam int IDX_EV1 = 2;
    localparam int IDX_EV2 = 3;
    localparam int IDX_EV3 = 4;
    localparam int IDX_EV4 = 5;
    localparam int IDX_CAA = 6;
    localparam int IDX_CAB = 7;
    localparam int IDX_AOFS = 8;
    localparam int IDX_PHASE = 9;
    localparam int IDX_ST1 = 10;
    localparam int IDX_ST2 = 11;
    localparam int IDX_BAB = 12;
    localparam int IDX_BAE = 13;
    localparam int IDX_BBB = 14;
    localparam int IDX_BBE = 15;
    localparam int NUM_CFG = 15;

    // ==========================================================
    // Control fields
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_MODE_MSB = 2;
    localparam int CTL_ASEL = 3;
    localparam int CTL_PSRC = 4;
    localparam int CTL_EN = 5;
    localparam int CTL_MSB = 5;

    // Status fields
    localparam int ST_A = 16;
    localparam int ST_B = 17;
    localparam int ST_BLA = 18;
    localparam int ST_BLB = 19;
    localparam int ST_MODE_LSB = 20;
    localparam int ST_MODE_MSB = 22;

    // ==========================================================
    // Reset values and constants
    localparam logic [DW-1:0] CFG_RST = 16'h0000;
    localparam logic [DW-1:0] PRD_RST = 16'h00FF;
    localparam logic [DW-1:0] CNT_ZERO = 16'h0000;
    localparam logic [DW:0] ONE_X = 17'h00001;

    // ==========================================================
    // Operating modes, Gray coded
    typedef enum logic [2:0] {
        MD_NORMAL = 3'h0,
        MD_MULTI = 3'h1,
        MD_RESON = 3'h3,
        MD_TRI = 3'h2,
        MD_LEAD = 3'h6
    } mpeg_mode_t;

    // Edge targets of one switching period
    typedef struct packed {
        logic [DW-1:0] a_rise;
        logic [DW-1:0] a_fall;
        logic [DW-1:0] b_rise;
        logic [DW-1:0] b_fall;
        logic [DW-1:0] adapt;
        logic [DW-1:0] phase;
        logic a_on;
        logic adapt_on;
    } mpeg_tgt_t;

    // Values frozen at period start
    typedef struct packed {
        logic [DW-1:0] duty;
        logic [DW-1:0] fper;
        logic [DW-1:0] period_value;
        logic [DW-1:0] aofs;
    } mpeg_snap_t;

endpackage

// ---- mpeg_core.sv ----
// Purpose: Multimode pwm edge generator around a period counter
// Assumes: Filter duty and period come from logic on clk
// Notes:   Edge arithmetic is modulo 2^16; multi mode B fall folds at the period
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps

module mpeg_core
    import mpeg_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic nrst, // Async reset, low
    input wire logic [AW-1:0] addr, // Register byte address
    input wire logic [BW-1:0] wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    output logic [BW-1:0] rdata, // Read data, next cycle
    input wire logic [DW-1:0] filt_duty, // Filter duty result
    input wire logic [DW-1:0] filt_period, // Filter period result
    output logic pwm_out_a, // Gate drive A
    output logic pwm_out_b, // Gate drive B
    output logic adapt_trig, // Adaptive sample trigger
    output logic samp_trig1, // Sample trigger 1
    output logic samp_trig2, // Sample trigger 2
    output logic blank_a, // Blanking window A
    output logic blank_b, // Blanking window B
    output logic phase_trig, // Phase trigger out
    output logic period_start // First cycle of period
);

    // ==========================================================
    // Functions
    // Folds a sum past the period back into range
    function automatic logic [DW-1:0] wrap_mod(
        input logic [DW:0] v,
        input logic [DW-1:0] lim
    );
        logic [DW:0] t;
        t = v - {1'b0, lim} - ONE_X;
        wrap_mod = (v > {1'b0, lim}) ? t[DW-1:0] : v[DW-1:0];
    endfunction

    // Modes whose pulse starts at event 1
    function automatic logic is_trailing(input mpeg_mode_t m);
        is_trailing = (m == MD_NORMAL) || (m == MD_MULTI) ||
            (m == MD_RESON);
    endfunction

    // Checks that a written mode code is one of the five
    function automatic logic mode_ok(input logic [2:0] m);
        mode_ok = (m == MD_NORMAL) || (m == MD_MULTI) ||
            (m == MD_RESON) || (m == MD_TRI) || (m == MD_LEAD);
    endfunction

    // ==========================================================
    // Declarations
    mpeg_mode_t mode_r;
    logic asel_r;
    logic psrc_r;
    logic en_r;
    logic [DW-1:0] cfg_r [1:NUM_CFG];
    logic [DW-1:0] cnt_r;
    logic [DW-1:0] cnt_nxt;
    logic run_r;
    logic wrap;
    logic [DW-1:0] lim;
    mpeg_snap_t snap_r;
    mpeg_tgt_t tg;
    logic [DW-1:0] dt1;
    logic [DW-1:0] dt2;
    logic [DW:0] dt_sum;
    logic [DW-1:0] dt_avg;
    logic [DW-1:0] half_d;
    logic [DW-1:0] half_p;
    logic [DW-1:0] a_end;
    logic [DW-1:0] a_beg;
    logic [DW:0] mb_sum;
    logic [DW-1:0] aa;
    logic [DW-1:0] ab;
    logic [AW-1:0] idx;
    logic cfg_hit;
    logic [BW-1:0] stat;

    // ==========================================================
    // Register port
    // Word index and config-range decode
    assign idx = addr >> ADR_LSB;
    assign cfg_hit = (addr[ADR_LSB-1:0] == 2'h0) &&
        (addr != OFS_CTRL) && (addr <= OFS_LAST_CFG);

    // Control register; invalid mode codes keep the old mode
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_r <= MD_NORMAL;
            asel_r <= 1'b0;
            psrc_r <= 1'b0;
            en_r <= 1'b0;
        end
        else if (wr_en && addr == OFS_CTRL)
        begin
            if (mode_ok(wdata[CTL_MODE_MSB:CTL_MODE_LSB]))
            begin
                mode_r <= mpeg_mode_t'(
                    wdata[CTL_MODE_MSB:CTL_MODE_LSB]);
            end
            asel_r <= wdata[CTL_ASEL];
            psrc_r <= wdata[CTL_PSRC];
            en_r <= wdata[CTL_EN];
        end
    end

    // One writable 16-bit register per config index
    genvar gi;
    generate
        for (gi = 1; gi <= NUM_CFG; gi++)
        begin : g_cfg
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    cfg_r[gi] <= (gi == IDX_PRD) ? PRD_RST : CFG_RST;
                end
                else if (wr_en && cfg_hit && idx == AW'(gi))
                begin
                    cfg_r[gi] <= wdata[DW-1:0];
                end
            end
        end
    endgenerate

    // Status word: counter, outputs and mode
    always_comb
    begin
        stat = '0;
        stat[DW-1:0] = cnt_r;
        stat[ST_A] = pwm_out_a;
        stat[ST_B] = pwm_out_b;
        stat[ST_BLA] = blank_a;
        stat[ST_BLB] = blank_b;
        stat[ST_MODE_MSB:ST_MODE_LSB] = mode_r;
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata <= '0;
        end
        else if (rd_en && addr == OFS_CTRL)
        begin
            rdata <= BW'({en_r, psrc_r, asel_r, mode_r});
        end
        else if (rd_en && addr == OFS_STAT)
        begin
            rdata <= stat;
        end
        else if (rd_en && cfg_hit)
        begin
            rdata <= BW'(cfg_r[idx]);
        end
        else
        begin
            rdata <= '0;
        end
    end

    // ==========================================================
    // Period counter
    // Resonant mode runs on the filter period
    assign lim = (mode_r == MD_RESON) ? snap_r.fper : snap_r.period_value;
    assign wrap = run_r && (cnt_r >= lim);
    assign cnt_nxt = wrap ? CNT_ZERO : cnt_r + 16'h0001;

    // Counter; held at zero while disabled
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_r <= CNT_ZERO;
            run_r <= 1'b0;
        end
        else if (!en_r)
        begin
            cnt_r <= CNT_ZERO;
            run_r <= 1'b0;
        end
        else
        begin
            run_r <= 1'b1;
            cnt_r <= run_r ? cnt_nxt : CNT_ZERO;
        end
    end

    // Snapshot of loop values taken as a period begins
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            snap_r <= '0;
        end
        else if (en_r && (!run_r || wrap))
        begin
            snap_r.duty <= filt_duty;
            snap_r.fper <= filt_period;
            snap_r.period_value <= cfg_r[IDX_PRD];
            snap_r.aofs <= cfg_r[IDX_AOFS];
        end
    end

    // ==========================================================
    // Edge targets
    // Shared terms of the mode equations
    assign half_d = snap_r.duty >> 1;
    assign half_p = snap_r.period_value >> 1;
    assign dt1 = cfg_r[IDX_EV3] - cfg_r[IDX_EV2];
    assign dt2 = cfg_r[IDX_EV1] + snap_r.period_value -
        cfg_r[IDX_EV4];
    assign dt_sum = {1'b0, dt1} + {1'b0, dt2};
    assign dt_avg = dt_sum[DW:1];
    assign a_end = cfg_r[IDX_EV1] + snap_r.duty + cfg_r[IDX_CAA];
    assign a_beg = cfg_r[IDX_EV1] - snap_r.duty + cfg_r[IDX_CAA];
    assign mb_sum = {1'b0, cfg_r[IDX_EV3]} + {1'b0, snap_r.duty} +
        {1'b0, cfg_r[IDX_CAB]};
    assign aa = cfg_r[IDX_EV1] + snap_r.duty + snap_r.aofs;
    assign ab = cfg_r[IDX_EV1] + half_d + snap_r.aofs;

    // Per-mode rise and fall points
    always_comb
    begin
        tg = '0;
        tg.a_on = 1'b1;
        tg.adapt_on = 1'b1;
        tg.adapt = asel_r ? ab : aa;
        tg.phase = psrc_r ? snap_r.duty : cfg_r[IDX_PHASE];
        case (mode_r)
            MD_NORMAL:
            begin
                tg.a_rise = cfg_r[IDX_EV1];
                tg.a_fall = a_end;
                tg.b_rise = a_end + dt1;
                tg.b_fall = cfg_r[IDX_EV4];
            end
            MD_MULTI:
            begin
                tg.a_rise = cfg_r[IDX_EV1];
                tg.a_fall = a_end;
                tg.b_rise = cfg_r[IDX_EV3];
                tg.b_fall = wrap_mod(mb_sum, lim);
            end
            MD_RESON:
            begin
                tg.a_rise = cfg_r[IDX_EV1];
                tg.a_fall = a_end - cfg_r[IDX_CAA] - dt_avg;
                tg.b_rise = tg.a_fall + dt1;
                tg.b_fall = snap_r.fper -
                    (snap_r.period_value - cfg_r[IDX_EV4]);
            end
            MD_TRI:
            begin
                tg.a_on = 1'b0;
                tg.adapt_on = 1'b0;
                tg.b_rise = half_p - half_d + cfg_r[IDX_CAA];
                tg.b_fall = half_p + half_d + cfg_r[IDX_CAB];
            end
            MD_LEAD:
            begin
                tg.a_fall = cfg_r[IDX_EV1];
                tg.a_rise = a_beg;
                tg.b_rise = cfg_r[IDX_EV4];
                tg.b_fall = a_beg - (cfg_r[IDX_EV2] -
                    cfg_r[IDX_EV3]);
                tg.adapt = asel_r ?
                    cfg_r[IDX_EV1] - half_d + snap_r.aofs :
                    cfg_r[IDX_EV1] - snap_r.duty + snap_r.aofs;
            end
            default:
            begin
                tg.a_on = 1'b0;
                tg.adapt_on = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Output edges
    // Output A; trailing modes end the pulse at the wrap
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pwm_out_a <= 1'b0;
        end
        else if (!run_r || !tg.a_on || cnt_r == tg.a_fall ||
            (wrap && is_trailing(mode_r)))
        begin
            pwm_out_a <= 1'b0;
        end
        else if (cnt_r == tg.a_rise)
        begin
            pwm_out_a <= 1'b1;
        end
    end

    // Output B; in multi mode a full-width pulse stays on
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pwm_out_b <= 1'b0;
        end
        else if (run_r && mode_r == MD_MULTI && cnt_r == tg.b_rise)
        begin
            pwm_out_b <= 1'b1;
        end
        else if (!run_r || cnt_r == tg.b_fall)
        begin
            pwm_out_b <= 1'b0;
        end
        else if (cnt_r == tg.b_rise)
        begin
            pwm_out_b <= 1'b1;
        end
    end

    // One-cycle trigger pulses
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            adapt_trig <= 1'b0;
            samp_trig1 <= 1'b0;
            samp_trig2 <= 1'b0;
            phase_trig <= 1'b0;
            period_start <= 1'b0;
        end
        else
        begin
            adapt_trig <= run_r && tg.adapt_on &&
                cnt_r == tg.adapt;
            samp_trig1 <= run_r && cnt_r == cfg_r[IDX_ST1];
            samp_trig2 <= run_r && cnt_r == cfg_r[IDX_ST2];
            phase_trig <= run_r && cnt_r == tg.phase;
            period_start <= run_r && cnt_r == CNT_ZERO;
        end
    end

    // Blanking windows, set at begin and cleared at end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            blank_a <= 1'b0;
            blank_b <= 1'b0;
        end
        else
        begin
            if (!run_r || cnt_r == cfg_r[IDX_BAE])
            begin
                blank_a <= 1'b0;
            end
            else if (cnt_r == cfg_r[IDX_BAB])
            begin
                blank_a <= 1'b1;
            end
            if (!run_r || cnt_r == cfg_r[IDX_BBE])
            begin
                blank_b <= 1'b0;
            end
            else if (cnt_r == cfg_r[IDX_BBB])
            begin
                blank_b <= 1'b1;
            end
        end
    end

endmodule

// ---- mpeg_filter_model.sv ----
// Purpose: Loop filter model feeding duty and period results
// Assumes: Results change on the rising clock edge
// Notes:   Period result is twice the duty result, modulo 2^16
`timescale 1ns/10ps
module mpeg_filter_model
    import mpeg_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic nrst, // Async reset, low
    input wire logic [DW-1:0] duty_set, // Requested duty
    output logic [DW-1:0] filt_duty, // Duty result
    output logic [DW-1:0] filt_period // Period result
);
    // ==========================================================
    // Filter results, registered like a real filter
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            filt_duty <= CFG_RST;
            filt_period <= CFG_RST;
        end
        else
        begin
            filt_duty <= duty_set;
            filt_period <= {duty_set[DW-2:0], 1'b0};
        end
    end
endmodule

// ---- mpeg_core_monitor.sv ----
// Purpose: Port level checks of the pwm edge generator
// Assumes: Bus writes are shadowed to know mode and period
// Notes:   Bound to every instance of the core
`timescale 1ns/10ps
module mpeg_core_monitor
    import mpeg_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic nrst, // Async reset, low
    input wire logic [AW-1:0] addr, // Register address
    input wire logic [BW-1:0] wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    input wire logic [BW-1:0] rdata, // Read data
    input wire logic [DW-1:0] filt_duty, // Filter duty
    input wire logic [DW-1:0] filt_period, // Filter period
    input wire logic pwm_out_a, // Gate A
    input wire logic pwm_out_b, // Gate B
    input wire logic adapt_trig, // Adaptive trigger
    input wire logic samp_trig1, // Sample trigger 1
    input wire logic samp_trig2, // Sample trigger 2
    input wire logic blank_a, // Blanking A
    input wire logic blank_b, // Blanking B
    input wire logic phase_trig, // Phase trigger
    input wire logic period_start // Period start
);
    logic [2:0] mode_r;
    logic [DW-1:0] prd_r;
    logic [DW:0] gap_r;
    logic [DW:0] age_r;
    logic seen_r;
    logic ctl_wr;
    logic prd_wr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // ==========================================================
    // Shadow of accepted mode and period value
    assign ctl_wr = wr_en && addr == OFS_CTRL;
    assign prd_wr = wr_en && addr == 8'h04;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_r <= 3'h0;
            prd_r <= PRD_RST;
        end
        else
        begin
            if (ctl_wr && wdata[2:0] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h6})
                mode_r <= wdata[2:0];
            if (prd_wr)
                prd_r <= wdata[DW-1:0];
        end
    end

    // Period length and quiet time since configuration
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gap_r <= '0;
            age_r <= '0;
            seen_r <= 1'b0;
        end
        else
        begin
            gap_r <= period_start ? ONE_X : gap_r + ONE_X;
            age_r <= (ctl_wr || prd_wr) ? '0 : age_r + ONE_X;
            seen_r <= ctl_wr ? 1'b0 : (seen_r | period_start);
        end
    end

    // ==========================================================
    // Assertions
    a_period_len: assert property (
        period_start && seen_r && age_r > gap_r + 4 && mode_r != MD_RESON
        |-> gap_r == {1'b0, prd_r} + ONE_X)
        else $error("period length differs from period value");
    a_start_pulse: assert property (
        period_start |=> !period_start)
        else $error("period start longer than one cycle");
    a_samp1_pulse: assert property (
        $rose(samp_trig1) |=> !samp_trig1)
        else $error("sample trigger 1 longer than one cycle");
    a_samp2_pulse: assert property (
        samp_trig2 |=> !samp_trig2)
        else $error("sample trigger 2 longer than one cycle");
    a_phase_pulse: assert property (
        phase_trig |=> !phase_trig)
        else $error("phase trigger longer than one cycle");
    a_adapt_pulse: assert property (
        adapt_trig |=> !adapt_trig)
        else $error("adaptive trigger longer than one cycle");
    a_tri_no_a: assert property (
        mode_r == MD_TRI && $past(mode_r) == MD_TRI |-> !$rose(pwm_out_a))
        else $error("output A rose in triangular mode");
    a_tri_no_adapt: assert property (
        mode_r == MD_TRI && $past(mode_r) == MD_TRI |-> !adapt_trig)
        else $error("adaptive trigger in triangular mode");
    a_rdata_idle: assert property (
        !rd_en |=> rdata == '0)
        else $error("read data without a read");
endmodule

bind mpeg_core mpeg_core_monitor mpeg_core_monitor_i (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .filt_duty(filt_duty),
    .filt_period(filt_period), .pwm_out_a(pwm_out_a),
    .pwm_out_b(pwm_out_b), .adapt_trig(adapt_trig),
    .samp_trig1(samp_trig1), .samp_trig2(samp_trig2), .blank_a(blank_a),
    .blank_b(blank_b), .phase_trig(phase_trig),
    .period_start(period_start));

// ---- tb_top.sv ----
// Purpose: Self checking bench of the pwm edge generator
// Assumes: Filter model gives period twice the duty
// Notes:   Edges are measured as counter values of one period
`timescale 1ns/10ps
module tb_top
    import mpeg_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [AW-1:0] addr = 8'h00;
    logic [BW-1:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [BW-1:0] rdata;
    logic [DW-1:0] duty_set = 16'h000C;
    logic [DW-1:0] filt_duty;
    logic [DW-1:0] filt_period;
    logic pwm_out_a, pwm_out_b, adapt_trig, samp_trig1, samp_trig2;
    logic blank_a, blank_b, phase_trig, period_start;
    int n_errors = 0;
    int n_tests = 0;
    logic [DW-1:0] ev [12];
    logic [DW-1:0] ex [12];
    logic [BW-1:0] rd_v;
    logic [7:0] prv, cur;
    string nm [12] = '{"a_rise", "a_fall", "b_rise", "b_fall", "adapt",
        "phase", "samp1", "samp2", "blka_on", "blka_off", "blkb_on",
        "blkb_off"};
    logic [DW-1:0] cfg [1:15] = '{16'h0027, 16'h0004, 16'h000A, 16'h000D,
        16'h0024, 16'h0002, 16'h0005, 16'h0003, 16'h0014, 16'h0007,
        16'h0019, 16'h0003, 16'h0006, 16'h001E, 16'h0021};

    // ==========================================================
    // Clock, design and filter model
    always #50 clk = ~clk;
    mpeg_core mpeg_core_i (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .filt_duty(filt_duty), .filt_period(filt_period),
        .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
        .adapt_trig(adapt_trig), .samp_trig1(samp_trig1),
        .samp_trig2(samp_trig2), .blank_a(blank_a), .blank_b(blank_b),
        .phase_trig(phase_trig), .period_start(period_start));
    mpeg_filter_model mpeg_filter_model_i (.clk(clk), .nrst(nrst),
        .duty_set(duty_set), .filt_duty(filt_duty),
        .filt_period(filt_period));

    // ==========================================================
    // Bus tasks, comparison and closing report
    task automatic chk(input string what, input logic [BW-1:0] exp,
        input logic [BW-1:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [BW-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [BW-1:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Samples the outputs until a period start, bounded
    task automatic wait_start();
        int k;
        k = 0;
        do
        begin
            @(negedge clk);
            prv = cur;
            cur = {pwm_out_a, pwm_out_b, adapt_trig, phase_trig,
                samp_trig1, samp_trig2, blank_a, blank_b};
            k++;
        end
        while (period_start !== 1'b1 && k < 200);
        if (period_start !== 1'b1)
        begin
            n_errors++;
            $display("mismatch period_start expected 1 seen 0");
            wrap_up();
        end
    endtask

    // Sets a mode, measures one clean period, duty changes mid-period
    task automatic run(input string tn, input logic [BW-1:0] ctl,
        input logic [DW-1:0] dty, input int n, input logic [DW-1:0] chg);
        logic [11:0] f;
        wr(OFS_CTRL, ctl);
        duty_set <= dty;
        wait_start();
        wait_start();
        for (int i = 0; i < 12; i++)
            ev[i] = 16'hFFFF;
        for (int p = 1; p <= n; p++)
        begin
            if (p > 1)
            begin
                @(negedge clk);
                prv = cur;
                cur = {pwm_out_a, pwm_out_b, adapt_trig, phase_trig,
                    samp_trig1, samp_trig2, blank_a, blank_b};
            end
            if (p == 10)
                duty_set <= chg;
            f = {prv[0] & ~cur[0], ~prv[0] & cur[0], prv[1] & ~cur[1],
                ~prv[1] & cur[1], cur[2], cur[3], cur[4], cur[5],
                prv[6] & ~cur[6], ~prv[6] & cur[6], prv[7] & ~cur[7],
                ~prv[7] & cur[7]};
            for (int i = 0; i < 12; i++)
                if (f[i] && ev[i] === 16'hFFFF)
                    ev[i] = 16'(p - 1);
        end
        for (int i = 0; i < 12; i++)
            chk(nm[i], {16'h0000, ex[i]}, {16'h0000, ev[i]});
        $display("test %s done", tn);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(8'h04, rd_v);
        chk("prd_reset", {16'h0000, PRD_RST}, rd_v);
        rd(8'h44, rd_v);
        chk("unmapped", 32'h0, rd_v);
        for (int i = 1; i <= NUM_CFG; i++)
            wr(8'(i << ADR_LSB), {16'h0000, cfg[i]});
        rd(8'h08, rd_v);
        chk("event1", 32'h4, rd_v);
        ex = '{16'h0004, 16'h0012, 16'h0015, 16'h0024, 16'h0013, 16'h0014,
            16'h0007, 16'h0019, 16'h0003, 16'h0006, 16'h001E, 16'h0021};
        run("normal", 32'h20, 16'h000C, 40, 16'h0014);
        wr(8'h10, 32'h1E);
        ex = '{16'h0004, 16'h0012, 16'h001E, 16'h0007, 16'h000D, 16'h000C,
            16'h0007, 16'h0019, 16'h0003, 16'h0006, 16'h001E, 16'h0021};
        run("multi", 32'h39, 16'h000C, 40, 16'h000C);
        wr(8'h10, 32'h0D);
        ex = '{16'h0004, 16'h0013, 16'h0016, 16'h0025, 16'h001B, 16'h0014,
            16'h0007, 16'h0019, 16'h0003, 16'h0006, 16'h001E, 16'h0021};
        run("resonant", 32'h23, 16'h0014, 41, 16'h0014);
        ex = '{16'hFFFF, 16'hFFFF, 16'h000F, 16'h001E, 16'hFFFF, 16'h0014,
            16'h0007, 16'h0019, 16'h0003, 16'h0006, 16'h001E, 16'h0021};
        run("triangular", 32'h22, 16'h000C, 40, 16'h000C);
        wr(8'h08, 32'h1E);
        ex = '{16'h0014, 16'h001E, 16'h0024, 16'h0017, 16'h001B, 16'h000C,
            16'h0007, 16'h0019, 16'h0003, 16'h0006, 16'h001E, 16'h0021};
        run("leading", 32'h3E, 16'h000C, 40, 16'h000C);
        run("mode_keep", 32'h3F, 16'h000C, 40, 16'h000C);
        rd(OFS_STAT, rd_v);
        chk("mode", 32'h6, {29'h0, rd_v[ST_MODE_MSB:ST_MODE_LSB]});
        wrap_up();
    end
endmodule
